// ### bench/spwm_tb.sv
`timescale 1ns/1ps
`include "spwm_defs.svh"

module testbench;
   localparam logic [1:0] respOk  = `SPWM_RESP_OKAY;
   localparam logic [1:0] respErr = `SPWM_RESP_SLVERR;
   logic        core_clk, reset, sleepReq;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        pwmOutputPin, pinOutputEnable, pinLevel;
   logic [2:0]  timerMatchFlag;
   logic [1:0]  wrQ[$];
   logic [33:0] rdQ[$];
   int          err_total = 0;
   int          checks = 0;
   int          hi, per, duty, fac, same;

   spwm_channel dut_u (
      .core_clk(core_clk), .reset(reset),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .sleepReq(sleepReq),
      .pwmOutputPin(pwmOutputPin), .pinOutputEnable(pinOutputEnable),
      .timerMatchFlag(timerMatchFlag)
   );

   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : cmpWord

   task automatic cmpResp(input string nm, input logic [1:0] e, input logic [1:0] g);
      cmpWord(nm, {30'h0, e}, {30'h0, g});
   endtask : cmpResp

   task automatic cmpCount(input string nm, input int e, input int g);
      checks++;
      if (g != e) begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask : cmpCount

   // a wait that ran out ends the run
   task automatic lost(input string nm);
      err_total++;
      $display("MISMATCH %s expected handshake seen timeout", nm);
      finish_test();
   endtask : lost

   function automatic logic [7:0] tmrAddr(input int n, input logic [1:0] r);
      return {`SPWM_TMR_REGION, 2'(n), r, 2'b00};
   endfunction : tmrAddr

   // write: address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, tA, tW;
      int   n;
      aw = 1'b1;
      w = 1'b1;
      wrQ.push_back(er);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50 && (aw || w); n++) begin
         @(negedge core_clk);
         tA = aw && s_axi_awready === 1'b1;
         tW = w && s_axi_wready === 1'b1;
         @(posedge core_clk);
         if (tA) s_axi_awvalid <= 1'b0;
         if (tW) s_axi_wvalid <= 1'b0;
         aw = aw && !tA;
         w = w && !tW;
      end
      if (aw || w) lost("write request");
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) @(negedge core_clk);
      if (s_axi_bvalid !== 1'b1) lost("write response");
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask : axw

   // read: rready held high until rvalid is seen
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      rdQ.push_back({ed, er});
      @(posedge core_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50 && s_axi_arready !== 1'b1; n++) @(negedge core_clk);
      if (s_axi_arready !== 1'b1) lost("read request");
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) @(negedge core_clk);
      if (s_axi_rvalid !== 1'b1) lost("read data");
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask : axr

   // bus answers are matched against the oldest note
   always @(posedge core_clk) begin
      logic [33:0] e;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         if (wrQ.size() == 0) lost("spare write response");
         else cmpResp("bresp", wrQ.pop_front(), s_axi_bresp);
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         if (rdQ.size() == 0) lost("spare read response");
         else begin
            e = rdQ.pop_front();
            cmpWord("rdata", e[33:2], s_axi_rdata);
            cmpResp("rresp", e[1:0], s_axi_rresp);
         end
      end
   end

   // high time and period of one whole pulse on the pin
   task automatic measure(output int h, output int p);
      int n;
      @(negedge core_clk);
      for (n = 0; n < 3000 && pwmOutputPin !== 1'b0; n++) @(negedge core_clk);
      for (n = 0; n < 3000 && pwmOutputPin !== 1'b1; n++) @(negedge core_clk);
      h = 0;
      while (pwmOutputPin === 1'b1 && h < 3000) begin h++; @(negedge core_clk); end
      p = h;
      while (pwmOutputPin === 1'b0 && p < 3000) begin p++; @(negedge core_clk); end
      if (p >= 3000) lost("pwm edge");
   endtask : measure

   // counts the cycles on which the pin shows level v
   task automatic hold(input logic v, input int cyc, output int s);
      s = 0;
      repeat (cyc) begin
         @(negedge core_clk);
         if (pwmOutputPin === v) s++;
      end
   endtask : hold

   // main sequence
   initial begin
      {reset, sleepReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(32'hf4d7f961));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      axr(`SPWM_OFS_DIR, 32'h1, respOk);
      axr(`SPWM_OFS_CTRL, 32'h0, respOk);
      axr(tmrAddr(0, `SPWM_TMR_PER), 32'h0, respOk);
      cmpWord("pin enable", 32'h0, {31'h0, pinOutputEnable});
      axr(8'h30, 32'h0, respErr);
      axw(8'h7c, 32'h0, respErr);
      // clean start on timer 0 with each prescale factor
      for (int i = 0; i < 3; i++) begin
         duty = 1 + $urandom % 15;
         fac = (i == 0) ? 1 : (i == 1) ? 4 : 16;
         axw(tmrAddr(0, `SPWM_TMR_CTRL), 32'h0, respOk);
         axw(`SPWM_OFS_DIR, 32'h1, respOk);
         axw(tmrAddr(0, `SPWM_TMR_PER), 32'h3, respOk);
         axw(`SPWM_OFS_CTRL, {26'h0, 2'(duty), 4'hc}, respOk);
         axw(`SPWM_OFS_DUTY, 32'(duty >> 2), respOk);
         axw(`SPWM_OFS_TSEL, 32'h0, respOk);
         axw(`SPWM_OFS_FLAG, 32'h7, respOk);
         axw(tmrAddr(0, `SPWM_TMR_CNT), 32'h0, respOk);
         axw(tmrAddr(0, `SPWM_TMR_CTRL), 32'(4 + i), respOk);
         for (int n = 0; n < 2000 && timerMatchFlag[0] !== 1'b1; n++) @(negedge core_clk);
         cmpWord("match flag", 32'h1, {31'h0, timerMatchFlag[0]});
         axw(`SPWM_OFS_DIR, 32'h0, respOk);
         cmpWord("pin enable", 32'h1, {31'h0, pinOutputEnable});
         measure(hi, per);
         cmpCount("high time", duty * fac, hi);
         cmpCount("period", 16 * fac, per);
         axw(`SPWM_OFS_ABUF, 32'haa, respOk);
         axr(`SPWM_OFS_ABUF, 32'(duty >> 2), respOk);
      end
      // duty beyond the period keeps the pin high
      axw(`SPWM_OFS_CTRL, 32'h3c, respOk);
      axw(`SPWM_OFS_DUTY, 32'hff, respOk);
      repeat (260) @(negedge core_clk);
      hold(1'b1, 512, same);
      cmpCount("stuck high", 512, same);
      // sleep freezes the timer and the pin
      @(posedge core_clk);
      sleepReq <= 1'b1;
      axw(tmrAddr(0, `SPWM_TMR_CNT), 32'h2, respOk);
      pinLevel = pwmOutputPin;
      cmpWord("sleep pin", 32'h1, {31'h0, pinLevel});
      hold(pinLevel, 300, same);
      cmpCount("sleep level", 300, same);
      axr(tmrAddr(0, `SPWM_TMR_CNT), 32'h2, respOk);
      @(posedge core_clk);
      sleepReq <= 1'b0;
      // zero duty keeps the pin low
      axw(`SPWM_OFS_CTRL, 32'h0c, respOk);
      axw(`SPWM_OFS_DUTY, 32'h0, respOk);
      repeat (260) @(negedge core_clk);
      hold(1'b0, 512, same);
      cmpCount("stuck low", 512, same);
      // timer 1 with period value 1 and duty 3
      axw(tmrAddr(1, `SPWM_TMR_PER), 32'h1, respOk);
      axw(`SPWM_OFS_CTRL, 32'h3c, respOk);
      axw(tmrAddr(1, `SPWM_TMR_CTRL), 32'h4, respOk);
      axw(`SPWM_OFS_TSEL, 32'h1, respOk);
      measure(hi, per);
      cmpCount("high time", 3, hi);
      cmpCount("period", 8, per);
      // full ten-bit resolution on timer 0 with period value 255 at 1:1
      duty = 1 + 4 * ($urandom % 256);
      axw(tmrAddr(0, `SPWM_TMR_PER), 32'hff, respOk);
      axw(tmrAddr(0, `SPWM_TMR_CTRL), 32'h4, respOk);
      axw(`SPWM_OFS_CTRL, 32'h1c, respOk);
      axw(`SPWM_OFS_DUTY, 32'(duty >> 2), respOk);
      axw(`SPWM_OFS_TSEL, 32'h0, respOk);
      measure(hi, per);
      cmpCount("high time", duty, hi);
      cmpCount("period", 1024, per);
      // a non-pwm mode and a cleared control register both release the pin
      axw(`SPWM_OFS_CTRL, 32'h04, respOk);
      cmpWord("pin enable", 32'h0, {31'h0, pinOutputEnable});
      axw(`SPWM_OFS_CTRL, 32'h0, respOk);
      cmpWord("pin enable", 32'h0, {31'h0, pinOutputEnable});
      // second reset in mid-run
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      axr(`SPWM_OFS_DIR, 32'h1, respOk);
      axr(tmrAddr(1, `SPWM_TMR_PER), 32'h0, respOk);
      finish_test();
   end

   // cuts a hang short
   initial begin
      repeat (100000) @(posedge core_clk);
      lost("run time");
   end
endmodule : testbench

// ### rtl/spwm_channel.sv
// What this block does
// - timer clears on the increment after it equals the period value
// - output goes high at each period restart unless duty is zero
// - duty value is copied into the active buffer at each period restart
// - duty is ten bits, duty byte on top, control bits five and four below
// - duty writes take effect only at the next period restart
// - active buffer is readable but ignores writes while in pwm mode
// - active buffer plus hidden two-bit latch double-buffer the duty
// - time base is count plus two phase or prescaler bits
// - output goes low when the time base equals the buffered duty
// - high time equals duty times prescale factor clock periods
// - duty beyond the period leaves the output unchanged
// - no postscaler takes part in setting the period
// - two-bit timer select picks one of three period timers
// - prescaler divides by one, four or sixteen
// - ten bits of resolution when the period value is 255
// - sleep freezes timers and channel, output holds its level
// - timer match flag sets at each period match
// - waveform reaches the pin only while the direction bit is clear
// - control register written to zero releases the pin
// - reset restores defaults and leaves the pin as an input
`timescale 1ns/1ps
`include "spwm_defs.svh"

module spwm_channel (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output      logic [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // axi4-lite read data
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   // power state
   input  wire logic        sleepReq,
   // pin side
   output      logic        pwmOutputPin,
   output      logic        pinOutputEnable,
   output      logic [2:0]  timerMatchFlag
);
   import spwm_pkg::*;

   spwm_state_s st_reg;
   spwm_state_s st_next;
   logic [2:0]  tick;
   logic [2:0]  restart;
   logic [1:0]  selIdx;
   logic        selValid;
   logic        restartSel;
   logic        pwmMode;
   logic [9:0]  tbNext;
   logic [9:0]  dutyNew;
   logic        wrFire;

   // prescaler terminal count per prescale code
   function automatic logic [5:0] pscLimit(input logic [1:0] psel);
      unique case (psel)
         `SPWM_PSEL_1: pscLimit = `SPWM_PSC_MAX_1;
         `SPWM_PSEL_4: pscLimit = `SPWM_PSC_MAX_4;
         default:      pscLimit = `SPWM_PSC_MAX_16;
      endcase
   endfunction : pscLimit

   // two low time-base bits: clock phase at 1:1, prescaler bits otherwise
   function automatic logic [1:0] tbLow(input logic [1:0] psel, input logic [5:0] psc);
      unique case (psel)
         `SPWM_PSEL_1: tbLow = psc[1:0];
         `SPWM_PSEL_4: tbLow = psc[3:2];
         default:      tbLow = psc[5:4];
      endcase
   endfunction : tbLow

   // word address inside a timer block
   function automatic logic isTimerAddr(input logic [7:0] addr);
      isTimerAddr = (addr[7:6] == `SPWM_TMR_REGION) && (addr[5:4] != 2'h3)
                    && (addr[3:2] != 2'h3) && (addr[1:0] == 2'h0);
   endfunction : isTimerAddr

   // handshake outputs
   assign s_axi_awready = !st_reg.awGot && !st_reg.bValid;
   assign s_axi_wready  = !st_reg.wGot && !st_reg.bValid;
   assign s_axi_arready = !st_reg.rValid;

   // registered outputs
   assign s_axi_bvalid    = st_reg.bValid;
   assign s_axi_bresp     = st_reg.bResp;
   assign s_axi_rvalid    = st_reg.rValid;
   assign s_axi_rdata     = st_reg.rData;
   assign s_axi_rresp     = st_reg.rResp;
   assign pwmOutputPin    = st_reg.pinOut;
   assign pinOutputEnable = st_reg.pinOe;
   assign timerMatchFlag  = st_reg.flag;

   // next-state logic for timers, channel and bus slave
   always_comb begin
      st_next    = st_reg;
      wrFire     = 1'b0;
      tick       = 3'h0;
      restart    = 3'h0;

      // period timers; only period and prescaler shape the period
      for (int i = 0; i < `SPWM_NUM_TMR; i++) begin
         tick[i]    = st_reg.run[i] && !sleepReq
                      && (st_reg.psc[i] >= pscLimit(st_reg.psel[i]));
         restart[i] = tick[i] && (st_reg.count[i] == st_reg.period[i]);
         if (st_reg.run[i] && !sleepReq) begin
            if (tick[i]) begin
               st_next.psc[i]   = 6'h00;
               st_next.count[i] = restart[i] ? 8'h00 : st_reg.count[i] + 8'h01;
            end else begin
               st_next.psc[i]   = st_reg.psc[i] + 6'h01;
            end
         end
      end

      // timer selection and mode decode
      selValid   = (st_reg.tsel != `SPWM_TSEL_NONE);
      selIdx     = selValid ? st_reg.tsel : 2'h0;
      restartSel = selValid && restart[selIdx];
      pwmMode    = (st_reg.mode[`SPWM_CTRL_MODE_MSB -: 2] == `SPWM_MODE_PWM_TOP)
                   && selValid;
      // time base after this edge; 8 count bits plus 2 low bits, 10 bits at 255
      tbNext     = {st_next.count[selIdx], tbLow(st_next.psel[selIdx], st_next.psc[selIdx])};
      dutyNew    = {st_reg.dutyByte, st_reg.dutyLow};

      // output generator, frozen in sleep
      if (!sleepReq) begin
         if (pwmMode) begin
            if (restartSel) begin
               st_next.activeBuf = st_reg.dutyByte;
               st_next.latchLow  = st_reg.dutyLow;
               st_next.pwmOut    = (dutyNew != 10'h000);
            end else if (tbNext == {st_reg.activeBuf, st_reg.latchLow}) begin
               st_next.pwmOut    = 1'b0;
            end
            // a duty beyond the period never matches and the pin stays put
         end else begin
            st_next.pwmOut = 1'b0;
         end
      end

      // write address and data capture in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.awGot  = 1'b1;
         st_next.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.wGot   = 1'b1;
         st_next.wData  = s_axi_wdata;
         st_next.wStrb0 = s_axi_wstrb[0];
      end
      if (st_reg.bValid && s_axi_bready) begin
         st_next.bValid = 1'b0;
      end

      // register write once both halves are held
      if (st_reg.awGot && st_reg.wGot) begin
         wrFire         = 1'b1;
         st_next.awGot  = 1'b0;
         st_next.wGot   = 1'b0;
         st_next.bValid = 1'b1;
         st_next.bResp  = `SPWM_RESP_OKAY;
         unique case (st_reg.awAddr)
            `SPWM_OFS_CTRL: if (st_reg.wStrb0) begin
               st_next.mode    = st_reg.wData[`SPWM_CTRL_MODE_MSB:0];
               st_next.dutyLow = st_reg.wData[`SPWM_CTRL_DLOW_MSB:`SPWM_CTRL_DLOW_LSB];
            end
            `SPWM_OFS_DUTY: if (st_reg.wStrb0) begin
               st_next.dutyByte = st_reg.wData[7:0];
            end
            `SPWM_OFS_ABUF: if (st_reg.wStrb0 && !pwmMode) begin
               st_next.activeBuf = st_reg.wData[7:0];
            end
            `SPWM_OFS_TSEL: if (st_reg.wStrb0) begin
               st_next.tsel = st_reg.wData[1:0];
            end
            `SPWM_OFS_DIR: if (st_reg.wStrb0) begin
               st_next.dirBit = st_reg.wData[0];
            end
            `SPWM_OFS_FLAG: if (st_reg.wStrb0) begin
               st_next.flag = st_next.flag & ~st_reg.wData[2:0];
            end
            default: begin
               if (!isTimerAddr(st_reg.awAddr)) begin
                  st_next.bResp = `SPWM_RESP_SLVERR;
               end else if (st_reg.wStrb0) begin
                  unique case (st_reg.awAddr[3:2])
                     `SPWM_TMR_CTRL: begin
                        st_next.run[st_reg.awAddr[5:4]]  =
                           st_reg.wData[`SPWM_TCTL_RUN_BIT];
                        st_next.psel[st_reg.awAddr[5:4]] = st_reg.wData[1:0];
                     end
                     `SPWM_TMR_PER: st_next.period[st_reg.awAddr[5:4]] = st_reg.wData[7:0];
                     default: begin
                        st_next.count[st_reg.awAddr[5:4]] = st_reg.wData[7:0];
                        st_next.psc[st_reg.awAddr[5:4]]   = 6'h00;
                     end
                  endcase
               end
            end
         endcase
      end

      // flag set after the clear so a match in the clearing cycle survives
      st_next.flag = st_next.flag | restart;

      // read channel, one cycle to data
      if (st_reg.rValid && s_axi_rready) begin
         st_next.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rValid = 1'b1;
         st_next.rResp  = `SPWM_RESP_OKAY;
         st_next.rData  = 32'h0000_0000;
         unique case (s_axi_araddr)
            `SPWM_OFS_CTRL: st_next.rData[5:0] = {st_reg.dutyLow, st_reg.mode};
            `SPWM_OFS_DUTY: st_next.rData[7:0] = st_reg.dutyByte;
            `SPWM_OFS_ABUF: st_next.rData[7:0] = st_reg.activeBuf;
            `SPWM_OFS_TSEL: st_next.rData[1:0] = st_reg.tsel;
            `SPWM_OFS_DIR:  st_next.rData[0]   = st_reg.dirBit;
            `SPWM_OFS_FLAG: st_next.rData[2:0] = st_reg.flag;
            default: begin
               if (!isTimerAddr(s_axi_araddr)) begin
                  st_next.rResp = `SPWM_RESP_SLVERR;
               end else begin
                  unique case (s_axi_araddr[3:2])
                     `SPWM_TMR_CTRL: st_next.rData[2:0] = {st_reg.run[s_axi_araddr[5:4]],
                                                          st_reg.psel[s_axi_araddr[5:4]]};
                     `SPWM_TMR_PER:  st_next.rData[7:0] = st_reg.period[s_axi_araddr[5:4]];
                     default:        st_next.rData[7:0] = st_reg.count[s_axi_araddr[5:4]];
                  endcase
               end
            end
         endcase
      end

      // pin driver: waveform only with pwm mode and the direction bit clear
      st_next.pinOe  = (st_next.mode[`SPWM_CTRL_MODE_MSB -: 2] == `SPWM_MODE_PWM_TOP)
                       && (st_next.tsel != `SPWM_TSEL_NONE) && !st_next.dirBit;
      st_next.pinOut = st_next.pinOe && st_next.pwmOut;
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg        <= '0;
         st_reg.dirBit <= `SPWM_DIR_RST;
         st_reg.period <= {`SPWM_NUM_TMR{`SPWM_PERIOD_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   // timer 0 returns to zero after its period match
   a_period_clear: assert property (@(posedge core_clk) disable iff (reset)
      restart[0] && !wrFire |=> st_reg.count[0] == 8'h00)
      else $error("timer 0 did not clear after period match");

   // restart raises the output for a non-zero duty
   a_restart_high: assert property (@(posedge core_clk) disable iff (reset)
      pwmMode && restartSel && (dutyNew != 10'h000) |=> st_reg.pwmOut)
      else $error("output not set at period restart");

   // zero duty keeps the output low through a restart
   a_zero_duty: assert property (@(posedge core_clk) disable iff (reset)
      pwmMode && restartSel && (dutyNew == 10'h000) |=> !st_reg.pwmOut)
      else $error("output set with zero duty");

   // restart transfers the written duty into the active buffer and latch
   a_duty_copy: assert property (@(posedge core_clk) disable iff (reset)
      pwmMode && restartSel |=> {st_reg.activeBuf, st_reg.latchLow} == $past(dutyNew))
      else $error("duty not transferred at restart");

   // active buffer holds between restarts in pwm mode
   a_buf_hold: assert property (@(posedge core_clk) disable iff (reset)
      pwmMode && !restartSel |=> $stable(st_reg.activeBuf) && $stable(st_reg.latchLow))
      else $error("active duty buffer changed outside a restart");

   // a time-base match drops the output
   a_match_low: assert property (@(posedge core_clk) disable iff (reset)
      pwmMode && !sleepReq && !restartSel && (tbNext == {st_reg.activeBuf, st_reg.latchLow})
      |=> !st_reg.pwmOut)
      else $error("output not cleared on duty match");

   // sleep freezes count and output
   a_sleep_freeze: assert property (@(posedge core_clk) disable iff (reset)
      sleepReq && !wrFire |=> $stable(st_reg.count) && $stable(st_reg.pwmOut))
      else $error("state changed during sleep");

   // match flag 0 follows each timer 0 period match
   a_flag_set: assert property (@(posedge core_clk) disable iff (reset)
      restart[0] |=> st_reg.flag[0])
      else $error("match flag not set");

   // direction bit set keeps the pin undriven
   a_dir_gate: assert property (@(posedge core_clk) disable iff (reset)
      st_reg.dirBit |-> !pinOutputEnable && !pwmOutputPin)
      else $error("pin driven with direction bit set");

   // zero control register releases the pin
   a_release: assert property (@(posedge core_clk) disable iff (reset)
      st_reg.mode == 4'h0 |-> !pinOutputEnable)
      else $error("pin held with control cleared");

endmodule : spwm_channel

// ### rtl/spwm_defs.svh
`ifndef SPWM_DEFS_SVH
`define SPWM_DEFS_SVH

// register byte offsets
`define SPWM_OFS_CTRL      8'h00
`define SPWM_OFS_DUTY      8'h04
`define SPWM_OFS_ABUF      8'h08
`define SPWM_OFS_TSEL      8'h0c
`define SPWM_OFS_DIR       8'h10
`define SPWM_OFS_FLAG      8'h14
// timer n sits at 0x40 + 0x10*n, addr[7:6] = 2'b01, addr[5:4] = n
`define SPWM_TMR_REGION    2'b01
`define SPWM_TMR_CTRL      2'h0
`define SPWM_TMR_PER       2'h1
`define SPWM_TMR_CNT       2'h2

// field positions
`define SPWM_CTRL_MODE_MSB 3
`define SPWM_CTRL_DLOW_LSB 4
`define SPWM_CTRL_DLOW_MSB 5
`define SPWM_TCTL_RUN_BIT  2
`define SPWM_MODE_PWM_TOP  2'b11
`define SPWM_TSEL_NONE     2'b11
`define SPWM_NUM_TMR       3

// prescale codes and prescaler terminal counts (4 phases times factor, minus one)
`define SPWM_PSEL_1        2'b00
`define SPWM_PSEL_4        2'b01
`define SPWM_PSC_MAX_1     6'h03
`define SPWM_PSC_MAX_4     6'h0f
`define SPWM_PSC_MAX_16    6'h3f

// reset values
`define SPWM_DIR_RST       1'b1
`define SPWM_PERIOD_RST    8'h00

// bus responses
`define SPWM_RESP_OKAY     2'b00
`define SPWM_RESP_SLVERR   2'b10

`endif

// ### rtl/spwm_pkg.sv
package spwm_pkg;

   typedef struct packed {
      logic [3:0]      mode;
      logic [1:0]      dutyLow;
      logic [7:0]      dutyByte;
      logic [7:0]      activeBuf;
      logic [1:0]      latchLow;
      logic [1:0]      tsel;
      logic            dirBit;
      logic [2:0]      flag;
      logic [2:0]      run;
      logic [2:0][1:0] psel;
      logic [2:0][7:0] period;
      logic [2:0][7:0] count;
      logic [2:0][5:0] psc;
      logic            pwmOut;
      logic            pinOut;
      logic            pinOe;
      logic            awGot;
      logic            wGot;
      logic [7:0]      awAddr;
      logic [31:0]     wData;
      logic            wStrb0;
      logic            bValid;
      logic [1:0]      bResp;
      logic            rValid;
      logic [31:0]     rData;
      logic [1:0]      rResp;
   } spwm_state_s;

endpackage : spwm_pkg
